// ==== bench/otgf_remote_model.sv ====
// behavioural remote otg device driving pin levels and bus states
`timescale 1ns/10ps

module otgf_remote_model (
	input  wire logic               i_clk_sys,    // system clock
	output otgf_pkg::otgf_line_in_t o_line,       // pin and comparator levels
	output logic                    o_se0,        // bus in se0
	output logic                    o_line_j,     // bus in j
	output logic                    o_line_k,     // bus in k
	output logic                    o_bus_idle,   // no bus activity
	output logic                    o_vbus_pulse, // vbus pulsing request
	output logic                    o_data_pulse  // data line pulsing request
);
	// quiet bus, mini-a plug and no vbus until told otherwise
	initial begin
		o_line = '0;
		{o_se0, o_line_j, o_line_k, o_bus_idle, o_vbus_pulse, o_data_pulse} = '0;
	end

	// new plug and comparator levels, taken off the sampling edge
	task automatic put_line(input otgf_pkg::otgf_line_in_t v);
		@(negedge i_clk_sys);
		o_line = v;
	endtask : put_line

	// hold se0 or idle for n edges; the caller drops it with a later call
	task automatic hold(input logic se0, input logic idle, input int n);
		@(negedge i_clk_sys);
		o_se0 = se0;
		o_bus_idle = idle;
		repeat (n) @(posedge i_clk_sys);
	endtask : hold

	// resume signalling: j then k on consecutive cycles
	task automatic resume();
		@(negedge i_clk_sys);
		o_line_j = 1'b1;
		@(negedge i_clk_sys);
		o_line_j = 1'b0;
		o_line_k = 1'b1;
		@(negedge i_clk_sys);
		o_line_k = 1'b0;
	endtask : resume

	// one-cycle session request by data line or vbus pulsing
	task automatic request(input logic by_data);
		@(negedge i_clk_sys);
		if (by_data) o_data_pulse = 1'b1;
		else o_vbus_pulse = 1'b1;
		@(negedge i_clk_sys);
		{o_data_pulse, o_vbus_pulse} = 2'h0;
	endtask : request
endmodule : otgf_remote_model

// ==== bench/testbench.sv ====
// self-checking bench for the otg status and event flag block
`timescale 1ns/10ps
`include "otgf_defines.svh"

module testbench;
	localparam int N_SE0 = 8;   // shortened se0 limit keeps the run brief
	localparam int N_IDLE = 12; // shortened idle limit
	localparam logic [7:0] RD = `OTGF_CMD_EVENT_RD;
	localparam logic [7:0] WR = `OTGF_CMD_EVENT_WR;
	logic i_clk_sys = 1'b0;          // system clock
	logic i_rst = 1'b1;              // reset
	logic tmr = 1'b0;                // timer time-out pulse
	logic sel = 1'b0;                // request method select
	otgf_pkg::otgf_cmd_t cmd = '0;   // host command
	otgf_pkg::otgf_line_in_t line;   // remote levels
	logic se0, lj, lk, idle, vp, dp; // remote bus states
	logic rd_valid;                  // read answer strobe
	logic [15:0] rd_data, status;    // read word and live status
	logic [15:0] exp_q[$];           // expected read words, oldest first
	logic [15:0] st_old;             // status before the latest change
	int err_count = 0;
	int total_checks = 0;

	always #25 i_clk_sys = ~i_clk_sys;

	otgf_remote_model u_remote (.i_clk_sys(i_clk_sys), .o_line(line), .o_se0(se0),
		.o_line_j(lj), .o_line_k(lk), .o_bus_idle(idle), .o_vbus_pulse(vp), .o_data_pulse(dp));

	otgf_event_flags #(.SE0_LONG_CYC(17'(N_SE0)), .IDLE_SUSP_CYC(17'(N_IDLE))) u_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_line(line), .i_se0(se0), .i_line_j(lj),
		.i_line_k(lk), .i_bus_idle(idle), .i_timer_expired(tmr), .i_vbus_pulse(vp),
		.i_data_pulse(dp), .i_request_method_select(sel), .i_cmd(cmd),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_line_status(status));

	// role-qualified status word expected for given levels
	function automatic logic [15:0] st_of(input otgf_pkg::otgf_line_in_t v);
		return {10'h000, v.remote_pullup, v.b_sess_above & v.id_pin,
			v.a_sess_above & ~v.id_pin, v.b_end_below & v.id_pin,
			v.a_vbus_above & ~v.id_pin, v.id_pin};
	endfunction : st_of

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic test_done();
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// one-cycle command strobe
	task automatic send(input logic [7:0] code, input logic [15:0] data);
		@(negedge i_clk_sys);
		cmd = '{1'b1, code, data};
		@(negedge i_clk_sys);
		cmd.valid = 1'b0;
	endtask : send

	// note the expected word, then ask for it
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		exp_q.push_back(exp);
		send(code, 16'h0000);
	endtask : rd

	// answers pair with notes in order; an unasked answer never matches
	always @(negedge i_clk_sys) begin
		if (rd_valid === 1'b1)
			check("read", exp_q.size() != 0 ? exp_q.pop_front() : ~rd_data, rd_data);
	end

	initial begin
		otgf_pkg::otgf_line_in_t v;
		void'($urandom(32'h75f62f94));
		repeat (3) @(posedge i_clk_sys);
		@(negedge i_clk_sys) i_rst = 1'b0;
		rd(RD, 16'h0000);
		st_old = 16'h0000;
		// random plug and vbus levels, change flags, zero and one writes
		for (int i = 0; i < 8; i++) begin
			v = 6'($urandom);
			u_remote.put_line(v);
			@(negedge i_clk_sys);
			check("status", st_of(v), status);
			rd(`OTGF_CMD_STATUS_RD, st_of(v));
			send(WR, 16'h0000);
			rd(RD, {10'h000, st_of(v) ^ st_old} & 16'h003f);
			send(WR, 16'hffff);
			rd(RD, 16'h0000);
			st_old = st_of(v);
		end
		// timer time-out, then one landing on its own clear
		@(negedge i_clk_sys) tmr = 1'b1;
		@(negedge i_clk_sys) tmr = 1'b0;
		rd(RD, 16'h0400);
		fork
			send(WR, 16'h0400);
			begin
				@(negedge i_clk_sys) tmr = 1'b1;
				@(negedge i_clk_sys) tmr = 1'b0;
			end
		join
		rd(RD, 16'h0400);
		send(WR, 16'hffff);
		// se0 exactly at the limit, then beyond it
		u_remote.hold(1'b1, 1'b0, N_SE0);
		u_remote.hold(1'b0, 1'b0, 1);
		rd(RD, 16'h0000);
		u_remote.hold(1'b1, 1'b0, N_SE0 + 2);
		@(negedge i_clk_sys);
		check("status", st_old | 16'h0200, status);
		u_remote.hold(1'b0, 1'b0, 1);
		rd(RD, 16'h0200);
		send(WR, 16'hffff);
		// j to k while active is no resume; idle into suspend, then resume
		u_remote.resume();
		u_remote.hold(1'b0, 1'b1, N_IDLE + 2);
		u_remote.resume();
		u_remote.hold(1'b0, 1'b0, 1);
		rd(RD, 16'h00c0);
		send(WR, 16'hffff);
		// each request method, with the other one offered first
		for (int m = 0; m < 2; m++) begin
			sel = m[0];
			u_remote.request(~m[0]);
			rd(RD, 16'h0000);
			u_remote.request(m[0]);
			rd(RD, 16'h0100);
			send(WR, 16'hffff);
		end
		for (int w = 0; w < 20 && exp_q.size() != 0; w++) @(negedge i_clk_sys);
		if (exp_q.size() != 0) err_count++;
		test_done();
	end
endmodule : testbench

// ==== design/otgf_defines.svh ====
// command codes, field positions, reset values and timing counts for the otg flag block
`ifndef OTGF_DEFINES_SVH
`define OTGF_DEFINES_SVH

`define OTGF_CMD_EVENT_RD   8'h68
`define OTGF_CMD_EVENT_WR   8'he8
`define OTGF_CMD_STATUS_RD  8'h67

`define OTGF_REG_W          16
`define OTGF_FLAG_W         11
`define OTGF_FLAGS_RESET    11'h000

`define OTGF_BIT_ID         0
`define OTGF_BIT_AVBUS      1
`define OTGF_BIT_BEND       2
`define OTGF_BIT_ASESS      3
`define OTGF_BIT_BSESS      4
`define OTGF_BIT_RMT        5
`define OTGF_BIT_SUSPEND    6
`define OTGF_BIT_RESUME     7
`define OTGF_BIT_SRP        8
`define OTGF_BIT_SE0        9
`define OTGF_BIT_TIMER      10

`define OTGF_CLK_MHZ        20
`define OTGF_SE0_LONG_US    2000
`define OTGF_IDLE_SUSP_US   3000
`define OTGF_SE0_LONG_CYC   (`OTGF_SE0_LONG_US * `OTGF_CLK_MHZ)
`define OTGF_IDLE_SUSP_CYC  (`OTGF_IDLE_SUSP_US * `OTGF_CLK_MHZ)
`define OTGF_CNT_W          17

`endif

// ==== design/otgf_event_flags.sv ====
// otg port live status bits and latched write-one-to-clear event flags
`timescale 1ns/10ps
`include "otgf_defines.svh"

// Functional notes
// RULE_01 - A-device: bit 3 shows vbus above session threshold
// RULE_02 - B-device: bit 2 shows vbus below end threshold
// RULE_03 - A-device: bit 1 shows vbus above valid threshold
// RULE_04 - bit 0 follows the id pin level
// RULE_05 - event register read 68, written e8, reserved high; the code reads reserved bits 15..11 as zero
// RULE_06 - timer time-out sets flag bit 10
// RULE_07 - writing one clears a flag, zero keeps
// RULE_08 - se0 longer than 2 ms sets bit 9
// RULE_09 - remote session request sets flag bit 8
// RULE_10 - only the selected request method is detected
// RULE_11 - j to k while suspended sets bit 7
// RULE_12 - entering suspend after 3 ms idle sets 6
// RULE_13 - change of status bits 5..0 sets flag
// RULE_14 - B-device: bit 4 shows vbus above session threshold
// RULE_15 - event in clear cycle keeps the flag set
module otgf_event_flags #(
	parameter logic [`OTGF_CNT_W-1:0] SE0_LONG_CYC  = 17'(`OTGF_SE0_LONG_CYC),  // 2 ms of se0
	parameter logic [`OTGF_CNT_W-1:0] IDLE_SUSP_CYC = 17'(`OTGF_IDLE_SUSP_CYC)  // 3 ms of idle
) (
	input  wire logic                  i_clk_sys,      // 20 mhz system clock
	input  wire logic                  i_rst,          // async reset, high
	input  wire otgf_pkg::otgf_line_in_t i_line,       // pin and comparator levels
	input  wire logic                  i_se0,          // bus in se0
	input  wire logic                  i_line_j,       // bus in j state
	input  wire logic                  i_line_k,       // bus in k state
	input  wire logic                  i_bus_idle,     // no bus activity
	input  wire logic                  i_timer_expired,// otg timer time-out pulse
	input  wire logic                  i_vbus_pulse,   // remote vbus pulse seen
	input  wire logic                  i_data_pulse,   // remote data line pulse seen
	input  wire logic                  i_request_method_select, // 1 data line, 0 vbus
	input  wire otgf_pkg::otgf_cmd_t   i_cmd,          // host command port
	output logic                       o_rd_valid,     // read data valid pulse
	output logic [`OTGF_REG_W-1:0]     o_rd_data,      // read data
	output logic [`OTGF_REG_W-1:0]     o_line_status   // live status word
);

	logic [`OTGF_FLAG_W-1:0]   otg_event_flags;   // latched events
	logic [5:0]                prev_status;       // status seen last cycle
	logic                      primed;            // prev_status holds real data
	logic                      line_was_j;        // bus was in j last cycle
	otgf_pkg::otgf_bus_state_t bus_state;         // suspend tracker
	wire                       se0_long;          // se0 beyond 2 ms
	wire                       se0_long_rise;     // se0 just passed 2 ms
	wire                       idle_long_rise;    // idle just passed 3 ms

	// live status bits, bits 1 to 4 role qualified by the id level
	wire id_level_status        = i_line.id_pin; // RULE_04
	wire a_session_valid_status = !i_line.id_pin && i_line.a_sess_above; // RULE_01
	wire b_session_end_status   = i_line.id_pin && i_line.b_end_below; // RULE_02
	wire a_vbus_valid_status    = !i_line.id_pin && i_line.a_vbus_above; // RULE_03
	wire b_session_valid_status = i_line.id_pin && i_line.b_sess_above; // RULE_14
	wire remote_pullup_status   = i_line.remote_pullup;
	wire [5:0] status_low = {remote_pullup_status, b_session_valid_status,
		a_session_valid_status, b_session_end_status, a_vbus_valid_status, id_level_status};

	// live status word; the status read and the pins both get it through one register stage
	wire [`OTGF_REG_W-1:0] line_word = {6'h00, se0_long, 3'h0, status_low};

	// command decode
	function automatic logic cmd_hit(input otgf_pkg::otgf_cmd_t c, input logic [7:0] code);
		cmd_hit = c.valid && (c.code == code);
	endfunction : cmd_hit

	wire rd_event  = cmd_hit(i_cmd, `OTGF_CMD_EVENT_RD); // RULE_05
	wire rd_status = cmd_hit(i_cmd, `OTGF_CMD_STATUS_RD);
	wire wr_event  = cmd_hit(i_cmd, `OTGF_CMD_EVENT_WR); // RULE_05

	// session request: only the method the host picked counts
	wire srp_seen = i_request_method_select ? i_data_pulse : i_vbus_pulse; // RULE_10

	// resume: j followed directly by k while the port is suspended
	wire resume_seen = (bus_state == otgf_pkg::OTGF_SUSPENDED) && line_was_j && i_line_k;

	// gather the events of this cycle
	wire [`OTGF_FLAG_W-1:0] events;
	assign events[5:0]                = primed ? (status_low ^ prev_status) : 6'h00; // RULE_13
	assign events[`OTGF_BIT_SUSPEND] = idle_long_rise; // RULE_12
	assign events[`OTGF_BIT_RESUME]  = resume_seen; // RULE_11
	assign events[`OTGF_BIT_SRP]     = srp_seen; // RULE_09
	assign events[`OTGF_BIT_SE0]     = se0_long_rise; // RULE_08
	assign events[`OTGF_BIT_TIMER]   = i_timer_expired; // RULE_06

	// clear mask from a host write; only the defined bits matter
	wire [`OTGF_FLAG_W-1:0] clr_mask  = wr_event ? i_cmd.data[`OTGF_FLAG_W-1:0] : '0; // RULE_07
	// a new event outranks a clear in the same cycle so nothing is lost
	wire [`OTGF_FLAG_W-1:0] next_flags = (otg_event_flags & ~clr_mask) | events; // RULE_15

	// read mux; reserved bits and unknown codes read as zero
	wire [`OTGF_REG_W-1:0] next_rd_data =
		rd_event  ? {5'h00, otg_event_flags} : // RULE_05
		rd_status ? line_word : '0;

	// se0 duration timer
	otgf_hold_timer #(
		.LIMIT (SE0_LONG_CYC)
	) u_se0_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_cond    (i_se0),
		.o_long    (se0_long),
		.o_rise    (se0_long_rise)
	);

	// idle duration timer, reused for suspend entry
	otgf_hold_timer #(
		.LIMIT (IDLE_SUSP_CYC)
	) u_idle_timer (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_cond    (i_bus_idle),
		.o_long    (),
		.o_rise    (idle_long_rise)
	);

	// event flag register
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			otg_event_flags <= `OTGF_FLAGS_RESET;
		else
			otg_event_flags <= next_flags;
	end

	// change detection history; first cycle after reset only samples, so reset is no change
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			prev_status <= 6'h00;
			primed      <= 1'b0;
			line_was_j  <= 1'b0;
		end else begin
			prev_status <= status_low;
			primed      <= 1'b1;
			line_was_j  <= i_line_j;
		end
	end

	// suspend tracker: enter after long idle, leave once the bus wakes
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			bus_state <= otgf_pkg::OTGF_ACTIVE;
		end else begin
			case (bus_state)
				otgf_pkg::OTGF_ACTIVE: begin
					if (idle_long_rise)
						bus_state <= otgf_pkg::OTGF_SUSPENDED;
				end
				otgf_pkg::OTGF_SUSPENDED: begin
					if (!i_bus_idle)
						bus_state <= otgf_pkg::OTGF_ACTIVE;
				end
				default: bus_state <= otgf_pkg::OTGF_ACTIVE;
			endcase
		end
	end

	// read port: data registered one cycle after the command
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rd_valid <= 1'b0;
			o_rd_data  <= '0;
		end else begin
			o_rd_valid <= rd_event || rd_status;
			o_rd_data  <= next_rd_data;
		end
	end

	// status pins from a flop; they trail the pin levels by one cycle
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			o_line_status <= '0;
		else
			o_line_status <= line_word;
	end

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	a_event_read_data: assert property (rd_event |=> o_rd_valid && // RULE_05
		o_rd_data == {5'h00, $past(otg_event_flags)})
		else $error("event read returned wrong data");
	a_reserved_zero: assert property (o_rd_data[15:11] == 5'h00 || $past(rd_status)) // RULE_05
		else $error("reserved event bits read nonzero");
	a_w1c_clear: assert property (wr_event && events == '0 |=> // RULE_07
		otg_event_flags == ($past(otg_event_flags) & ~$past(i_cmd.data[10:0])))
		else $error("write one to clear misbehaved");
	a_set_beats_clear: assert property (|events |=> // RULE_15
		(($past(events) & ~otg_event_flags) == '0))
		else $error("event lost against a clear");
	a_timer_sets: assert property (i_timer_expired |=> otg_event_flags[10]) // RULE_06
		else $error("timer time-out flag not set");
	a_se0_long_sets: assert property ($rose(se0_long) |-> otg_event_flags[9]) // RULE_08
		else $error("long se0 flag not set");
	a_srp_method: assert property (i_request_method_select && !i_data_pulse && // RULE_10
		!otg_event_flags[8] |=> !otg_event_flags[8])
		else $error("unselected request method detected");
	a_resume_only_susp: assert property ($rose(otg_event_flags[7]) |-> // RULE_11
		$past(bus_state) == otgf_pkg::OTGF_SUSPENDED)
		else $error("resume flagged outside suspend");
	a_id_change_sets: assert property (primed && $changed(i_line.id_pin) |=> // RULE_13
		otg_event_flags[0])
		else $error("id change not flagged");
	a_bend_status: assert property (primed |-> o_line_status[2] == // RULE_02
		$past(i_line.id_pin && i_line.b_end_below))
		else $error("b session end status wrong");
	a_id_status: assert property (primed |-> o_line_status[0] == $past(i_line.id_pin)) // RULE_04
		else $error("id level status wrong");
	a_avbus_status: assert property (primed |-> o_line_status[1] == // RULE_03
		$past(!i_line.id_pin && i_line.a_vbus_above))
		else $error("a vbus valid status wrong");
	a_asess_status: assert property (primed |-> o_line_status[3] == // RULE_01
		$past(!i_line.id_pin && i_line.a_sess_above))
		else $error("a session valid status wrong");
	a_bsess_status: assert property (primed |-> o_line_status[4] == // RULE_14
		$past(i_line.id_pin && i_line.b_sess_above))
		else $error("b session valid status wrong");
	a_srp_sets: assert property (!i_request_method_select && i_vbus_pulse |=> // RULE_09
		otg_event_flags[8])
		else $error("session request not flagged");
	a_suspend_sets: assert property (idle_long_rise |=> otg_event_flags[6]) // RULE_12
		else $error("suspend entry not flagged");

	c_timer_flag: cover property (i_timer_expired && wr_event && i_cmd.data[10] ##1
		otg_event_flags[10]);
	c_resume: cover property ($rose(otg_event_flags[7]));
	c_suspend: cover property ($rose(otg_event_flags[6]));

endmodule : otgf_event_flags

// ==== design/otgf_hold_timer.sv ====
// counts how long a bus condition has held and flags when it exceeds a limit
`timescale 1ns/10ps
`include "otgf_defines.svh"

module otgf_hold_timer #(
	parameter logic [`OTGF_CNT_W-1:0] LIMIT = 17'h00010 // cycles that must be exceeded
) (
	input  wire logic i_clk_sys, // system clock
	input  wire logic i_rst,     // async reset, high
	input  wire logic i_cond,    // condition being timed
	output logic      o_long,    // condition held beyond the limit
	output logic      o_rise     // one-cycle pulse in the cycle before o_long goes high
);

	logic [`OTGF_CNT_W-1:0] count; // cycles the condition has held
	wire                    over = (count == LIMIT) && i_cond;

	// counter saturates at the limit so o_long stays up while the condition lasts
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			count  <= '0;
			o_long <= 1'b0;
		end else if (!i_cond) begin
			count  <= '0;
			o_long <= 1'b0;
		end else begin
			if (!o_long && count != LIMIT)
				count <= count + 1'b1;
			if (over)
				o_long <= 1'b1;
		end
	end

	assign o_rise = over && !o_long;

endmodule : otgf_hold_timer

// ==== design/otgf_pkg.sv ====
// types shared by the otg status and event flag block
package otgf_pkg;

	// analogue comparator and pin levels from the port front end
	typedef struct packed {
		logic id_pin;       // id pin level
		logic a_vbus_above; // vbus above a_vbus_threshold
		logic b_end_below;  // vbus below b_end_threshold
		logic a_sess_above; // vbus above a_session_threshold
		logic b_sess_above; // vbus above b_session_threshold
		logic remote_pullup;// remote pull-up seen on the bus
	} otgf_line_in_t;

	// host command port request
	typedef struct packed {
		logic        valid; // command strobe
		logic [7:0]  code;  // command code
		logic [15:0] data;  // write data
	} otgf_cmd_t;

	// suspend tracking
	typedef enum logic {
		OTGF_ACTIVE,
		OTGF_SUSPENDED
	} otgf_bus_state_t;

endpackage : otgf_pkg
